// >>> hdl/omt_top.sv
// oscillator mode selection, internal block, postscaler and trim register
// Function
// - external clock mode: clock from osc_in, no start-up delay
// - external clock mode: osc_out pin is port A bit six I/O
// - RC mode: osc_out drives oscillator divided by four
// - RC with I/O mode: like RC, osc_out is port A bit six
// - main internal clock is 8 MHz, drives system clock and postscaler
// - postscaler gives six frequencies from 125 kHz to 4 MHz
// - low-frequency RC runs at 31.25 kHz, 32 us period
// - low RC runs when selected with use_internal_sysclk set or timer, watchdog, start-up, monitor enabled
// - internal frequency select picks main, low RC or postscaler tap
// - internal clkout mode: osc_out gives clock/4, osc_in is bit seven
// - internal dual I/O mode: both osc pins are port A I/O
// - trim is two's complement: 0 centre, 011111 max, 100000 min
// - trim spans plus or minus 12.5 percent in equal steps
// - after trim write low RC settles in 8 cycles, main in 1 ms
// - no completion flag; operation continues during the shift
// - watchdog and monitor timing follow the trimmed low RC
// - trim bits 7-6 read zero; six bits read/write, reset zero
// - select encodes 000 low RC up to 111 8 MHz
// - 3-bit config field selects one of eight oscillator modes
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "omt_consts.svh"
module omt_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // configuration
    input wire omt_pkg::omt_mode_e oscillator_mode_config,
    input wire logic use_internal_sysclk,
    input wire logic pwrup_timer_en,
    input wire logic watchdog_timer_en,
    input wire logic two_speed_en,
    input wire logic fail_safe_en,
    // oscillator pins
    input wire logic osc_in_pin,
    output logic osc_out_o,
    output logic osc_out_oe,
    // port a pin ownership
    output logic port_a_bit_six_is_io,
    output logic port_a_bit_seven_is_io,
    // clocks
    output logic sys_clk,
    output logic low_freq_internal_rc,
    output logic main_internal_clock,
    output logic ext_startup_wait
);
    import omt_pkg::*;
    typedef struct packed {
        omt_trim_t trim;
        logic [2:0] ifs;
        logic [1:0] in_sync;
        logic [7:0] post;
        logic main_prev;
        logic [1:0] div4;
        logic sys_prev;
        logic out;
        logic [31:0] main_settle;
        logic [31:0] lf_settle;
    } omt_top_s;
    omt_top_s s_q, s_d;
    logic lf_run, main_clk, lf_clk, wr_en, rd_en, ext_mode, sel_clk;
    logic [31:0] rdata;
    logic [7:0] taps;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign ext_mode = (oscillator_mode_config == OMT_EXT_IO);
    // low RC also feeds watchdog/monitor timing, so it stays trimmed
    assign lf_run = (use_internal_sysclk && s_q.ifs == 3'h0) || pwrup_timer_en
        || watchdog_timer_en || two_speed_en || fail_safe_en;

    omt_tuned_osc #(.NOM_HALF(`OMT_MAIN_HALF)) u_main (
        .pclk(pclk),
        .presetn(presetn),
        .run(1'b1),
        .trim(s_q.trim),
        .clk_out(main_clk)
    );
    omt_tuned_osc #(.NOM_HALF(`OMT_LF_HALF)) u_lf (
        .pclk(pclk),
        .presetn(presetn),
        .run(lf_run),
        .trim(s_q.trim),
        .clk_out(lf_clk)
    );

    // tap k of the ripple chain is 8 MHz / 2^(k+1): 4 MHz down to 125 kHz
    assign taps = s_q.post;
    always_comb begin
        unique case (s_q.ifs)
            3'h0: sel_clk = lf_clk;
            3'h1: sel_clk = taps[5];
            3'h2: sel_clk = taps[4];
            3'h3: sel_clk = taps[3];
            3'h4: sel_clk = taps[2];
            3'h5: sel_clk = taps[1];
            3'h6: sel_clk = taps[0];
            3'h7: sel_clk = main_clk;
        endcase
    end

    always_comb begin
        rdata = '0;
        if (paddr == `OMT_ADDR_TRIM) begin
            rdata[5:0] = s_q.trim;
        end else if (paddr == `OMT_ADDR_CTRL) begin
            rdata[6:4] = s_q.ifs;
        end else if (paddr == `OMT_ADDR_STAT) begin
            rdata[2:0] = oscillator_mode_config;
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.in_sync = {s_q.in_sync[0], osc_in_pin};
        s_d.main_prev = main_clk;
        if (main_clk && !s_q.main_prev) begin
            s_d.post = s_q.post + 8'h01;
        end
        if (wr_en && paddr == `OMT_ADDR_TRIM) begin
            s_d.trim = pwdata[5:0];
            // settle timers are internal only; nothing reports completion
            s_d.main_settle = `OMT_MAIN_SETTLE;
            s_d.lf_settle = `OMT_LF_SETTLE;
        end else begin
            if (s_q.main_settle != 0) s_d.main_settle = s_q.main_settle - 32'd1;
            if (s_q.lf_settle != 0) s_d.lf_settle = s_q.lf_settle - 32'd1;
        end
        if (wr_en && paddr == `OMT_ADDR_CTRL) begin
            s_d.ifs = pwdata[6:4];
        end
        // clock/4 output counts rising edges of the running system clock
        s_d.sys_prev = sys_clk;
        if (sys_clk && !s_q.sys_prev) begin
            s_d.div4 = s_q.div4 + 2'h1;
            if (s_q.div4 == 2'h1 || s_q.div4 == 2'h3) begin
                s_d.out = ~s_q.out;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.trim <= `OMT_TRIM_RESET;
            s_q.ifs <= `OMT_IFS_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (rd_en) begin
            prdata <= rdata;
        end
    end

    // unmapped addresses read zero; writes are dropped silently
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    always_comb begin
        sys_clk = 1'b0;
        osc_out_o = 1'b0;
        osc_out_oe = 1'b0;
        port_a_bit_six_is_io = 1'b0;
        port_a_bit_seven_is_io = 1'b0;
        ext_startup_wait = 1'b0;
        unique case (oscillator_mode_config)
            OMT_LP, OMT_XT, OMT_HS: begin
                sys_clk = s_q.in_sync[1];
                ext_startup_wait = 1'b1;
            end
            OMT_RC: begin
                sys_clk = s_q.in_sync[1];
                osc_out_o = s_q.out;
                osc_out_oe = 1'b1;
            end
            OMT_RC_WITH_IO_MODE: begin
                sys_clk = s_q.in_sync[1];
                port_a_bit_six_is_io = 1'b1;
            end
            OMT_INT_CLKOUT: begin
                sys_clk = sel_clk;
                osc_out_o = s_q.out;
                osc_out_oe = 1'b1;
                port_a_bit_seven_is_io = 1'b1;
            end
            OMT_INT_DUAL_IO: begin
                sys_clk = sel_clk;
                port_a_bit_six_is_io = 1'b1;
                port_a_bit_seven_is_io = 1'b1;
            end
            OMT_EXT_IO: begin
                sys_clk = s_q.in_sync[1];
                port_a_bit_six_is_io = 1'b1;
            end
        endcase
        if (use_internal_sysclk && oscillator_mode_config != OMT_INT_CLKOUT
            && oscillator_mode_config != OMT_INT_DUAL_IO) begin
            sys_clk = sel_clk;
        end
    end
    assign low_freq_internal_rc = lf_clk;
    assign main_internal_clock = main_clk;

    property p_trim_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == `OMT_ADDR_TRIM) |=> (s_q.trim == $past(pwdata[5:0]));
    endproperty
    a_trim_write: assert property (p_trim_write) else $error("trim not stored");
    property p_trim_read_high_zero;
        @(posedge pclk) disable iff (!presetn)
        $past(rd_en && paddr == `OMT_ADDR_TRIM) |-> (prdata[31:6] == 26'h0 && prdata[5:0] == $past(s_q.trim));
    endproperty
    a_trim_read_high_zero: assert property (p_trim_read_high_zero) else $error("bad trim read");
    property p_ext_io;
        @(posedge pclk) disable iff (!presetn)
        ext_mode |-> (port_a_bit_six_is_io && !osc_out_oe && !ext_startup_wait);
    endproperty
    a_ext_io: assert property (p_ext_io) else $error("ext mode pins wrong");
    property p_rc_out;
        @(posedge pclk) disable iff (!presetn)
        (oscillator_mode_config == OMT_RC) |-> (osc_out_oe && osc_out_o == s_q.out);
    endproperty
    a_rc_out: assert property (p_rc_out) else $error("rc out not driven");
    property p_rc_with_io_mode;
        @(posedge pclk) disable iff (!presetn)
        (oscillator_mode_config == OMT_RC_WITH_IO_MODE) |-> (port_a_bit_six_is_io && !osc_out_oe);
    endproperty
    a_rc_with_io_mode: assert property (p_rc_with_io_mode) else $error("rc_with_io_mode pin wrong");
    property p_int_clkout;
        @(posedge pclk) disable iff (!presetn)
        (oscillator_mode_config == OMT_INT_CLKOUT) |-> (osc_out_oe && port_a_bit_seven_is_io && !port_a_bit_six_is_io);
    endproperty
    a_int_clkout: assert property (p_int_clkout) else $error("clkout mode pins wrong");
    property p_int_dual;
        @(posedge pclk) disable iff (!presetn)
        (oscillator_mode_config == OMT_INT_DUAL_IO) |-> (port_a_bit_six_is_io && port_a_bit_seven_is_io && !osc_out_oe);
    endproperty
    a_int_dual: assert property (p_int_dual) else $error("dual io pins wrong");
    property p_lf_run;
        @(posedge pclk) disable iff (!presetn)
        (watchdog_timer_en || fail_safe_en || pwrup_timer_en || two_speed_en) |-> lf_run;
    endproperty
    a_lf_run: assert property (p_lf_run) else $error("low rc not enabled");
    property p_settle_load;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == `OMT_ADDR_TRIM) |=> (s_q.lf_settle == `OMT_LF_SETTLE && s_q.main_settle == `OMT_MAIN_SETTLE);
    endproperty
    a_settle_load: assert property (p_settle_load) else $error("settle timers not loaded");
endmodule

// >>> hdl/omt_consts.svh
// constants for the oscillator mode and trim block
`ifndef OMT_CONSTS_SVH
`define OMT_CONSTS_SVH
`define OMT_ADDR_TRIM 12'h090
`define OMT_ADDR_CTRL 12'h08F
`define OMT_ADDR_STAT 12'h0A0
`define OMT_TRIM_RESET 6'h00
`define OMT_IFS_RESET 3'h0
`define OMT_IFS_LSB 4
`define OMT_TRIM_LSB 0
`define OMT_CLK_HZ 250000000
`define OMT_MAIN_HZ 8000000
`define OMT_LF_HZ 31250
`define OMT_MAIN_SETTLE_US 1000
`define OMT_LF_SETTLE_CYC 8
`define OMT_MAIN_HALF ((`OMT_CLK_HZ / `OMT_MAIN_HZ) / 2)
`define OMT_LF_HALF ((`OMT_CLK_HZ / `OMT_LF_HZ) / 2)
`define OMT_MAIN_SETTLE ((`OMT_CLK_HZ / 1000000) * `OMT_MAIN_SETTLE_US)
`define OMT_LF_SETTLE (`OMT_LF_SETTLE_CYC * 2 * `OMT_LF_HALF)
`endif

// >>> hdl/omt_pkg.sv
// types for the oscillator mode and trim block
package omt_pkg;
    typedef enum logic [2:0] {
        OMT_LP, OMT_XT, OMT_HS, OMT_RC, OMT_RC_WITH_IO_MODE, OMT_INT_CLKOUT, OMT_INT_DUAL_IO, OMT_EXT_IO
    } omt_mode_e;
    typedef logic [5:0] omt_trim_t;
endpackage

// >>> hdl/omt_tuned_osc.sv
// trimmed square-wave source standing in for an internal oscillator
`timescale 1ns/1ps
`include "omt_consts.svh"
module omt_tuned_osc #(
    parameter int NOM_HALF = 15
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic run,
    input wire omt_pkg::omt_trim_t trim,
    // output
    output logic clk_out
);
    import omt_pkg::*;
    // one code moves the half period by 12.5/32 percent; a short nominal rounds to few steps
    typedef struct packed {
        logic [31:0] cnt;
        logic clk;
    } omt_osc_s;
    omt_osc_s s_q, s_d;
    logic [31:0] half;
    always_comb begin
        // positive trim raises frequency, so the half period shrinks
        half = 32'(NOM_HALF - (NOM_HALF * $signed(trim) * 125) / 32000);
        s_d = s_q;
        if (!run) begin
            s_d.cnt = '0;
            s_d.clk = 1'b0;
        end else if (s_q.cnt + 32'd1 >= half) begin
            s_d.cnt = '0;
            s_d.clk = ~s_q.clk;
        end else begin
            s_d.cnt = s_q.cnt + 32'd1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign clk_out = s_q.clk;
endmodule

// >>> sim/omt_ext_src.sv
// external clock source standing in for the part on the oscillator input
`timescale 1ns/1ps
module omt_ext_src #(
    parameter real HALF_NS = 80.0
) (
    // control
    input wire logic run,
    // pin
    output logic osc_in_pin
);
    initial begin
        osc_in_pin = 1'b0;
        // odd offset keeps the source out of phase with the bus clock
        #1.3;
        forever begin
            #(HALF_NS);
            // a halted source stands low and gives no edges
            osc_in_pin = run ? ~osc_in_pin : 1'b0;
        end
    end
endmodule

// >>> sim/omt_top_test.sv
// register, pin ownership and clock rate tests for the oscillator block
`timescale 1ns/1ps
`include "omt_consts.svh"
module omt_top_test;
    import omt_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, use_int, pwr_en, wdt_en, two_en, fs_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    omt_mode_e mode;
    logic osc_in, osc_o, osc_oe, b6, b7, sysc, lfrc, mainc, stw, ext_run, p, perr;
    int fails, n_compared, cyc, per, n, tog, e;
    logic [3:0] tab [8] = '{4'h8, 4'h8, 4'h8, 4'h1, 4'h2, 4'h5, 4'h6, 4'h2};
    logic [3:0] msk [8] = '{4'hE, 4'hE, 4'hE, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF};

    omt_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .oscillator_mode_config(mode), .use_internal_sysclk(use_int), .pwrup_timer_en(pwr_en),
        .watchdog_timer_en(wdt_en), .two_speed_en(two_en), .fail_safe_en(fs_en), .osc_in_pin(osc_in),
        .osc_out_o(osc_o), .osc_out_oe(osc_oe), .port_a_bit_six_is_io(b6), .port_a_bit_seven_is_io(b7),
        .sys_clk(sysc), .low_freq_internal_rc(lfrc), .main_internal_clock(mainc), .ext_startup_wait(stw));
    omt_ext_src u_src (.run(ext_run), .osc_in_pin(osc_in));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t value %h expected %h", $time, got, exp);
        end
    endtask

    task chk_rng(input int got, input int lo, input int hi);
        n_compared++;
        if (got < lo || got > hi) begin
            fails++;
            $display("ERROR t=%0t period %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask

    // read data and error are taken at the rising edge that sees pready high, then released
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask

    task rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk_val(q, exp);
    endtask

    function logic pick(input int w);
        case (w)
            0: return sysc;
            1: return lfrc;
            2: return mainc;
            default: return osc_o;
        endcase
    endfunction

    // waveforms are looked at mid-cycle, so registered edges have landed
    task rise(input int w, output int k);
        logic c, q;
        q = pick(w);
        k = 0;
        while (1) begin
            @(negedge pclk);
            k++;
            c = pick(w);
            if (q === 1'b0 && c === 1'b1) break;
            q = c;
        end
    endtask

    task meas(input int w, output int k);
        int j;
        rise(w, j);
        rise(w, k);
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        // worst case of the sequence below is about 92000 cycles
        if (cyc == 98000) begin
            fails = fails + 1;
            end_sim;
        end
    end

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
        mode = omt_mode_e'(3'h5); use_int = 1'b1; pwr_en = 1'b0; wdt_en = 1'b1; two_en = 1'b0;
        fs_en = 1'b0; ext_run = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(`OMT_ADDR_TRIM, 32'h0);
        rd(`OMT_ADDR_CTRL, 32'h0);
        wr(`OMT_ADDR_TRIM, 32'hFFFFFFFF);
        rd(`OMT_ADDR_TRIM, 32'h3F);
        chk_val(32'(perr), 32'h0);
        wr(`OMT_ADDR_TRIM, 32'h20);
        rd(`OMT_ADDR_TRIM, 32'h20);
        wr(`OMT_ADDR_TRIM, 32'h0);
        wr(`OMT_ADDR_CTRL, 32'hFF);
        rd(`OMT_ADDR_CTRL, 32'h70);
        wr(12'h0C0, 32'hFFFFFFFF);
        rd(12'h0C0, 32'h0);
        for (int m = 0; m < 8; m++) begin
            @(posedge pclk);
            mode <= omt_mode_e'(m[2:0]);
            @(negedge pclk);
            chk_val({stw, b7, b6, osc_oe} & msk[m], tab[m]);
            rd(`OMT_ADDR_STAT, m);
        end
        @(posedge pclk);
        mode <= omt_mode_e'(3'h5);
        for (int s = 1; s < 8; s++) begin
            wr(`OMT_ADDR_CTRL, 32'(s) << 4);
            meas(0, per);
            e = 250000000 / (125000 << (s - 1));
            chk_rng(per, e * 9 / 10, e * 11 / 10);
        end
        meas(3, per);
        chk_rng(per, 112, 137);
        meas(2, per);
        chk_rng(per, 27, 34);
        meas(1, per);
        chk_rng(per, 7840, 8160);
        // raise the trim to its top code and let the slow source settle
        wr(`OMT_ADDR_TRIM, 32'h1F);
        repeat (7) rise(1, n);
        meas(1, per);
        chk_rng(per, 6900, 7600);
        @(posedge pclk);
        mode <= omt_mode_e'(3'h7);
        use_int <= 1'b0;
        wdt_en <= 1'b0;
        ext_run <= 1'b1;
        meas(0, per);
        chk_rng(per, 40, 40);
        tog = 0;
        p = lfrc;
        // longer than any trimmed half period, so a running source would toggle
        repeat (4600) begin
            @(negedge pclk);
            if (lfrc !== p) tog++;
            p = lfrc;
        end
        chk_val(tog, 0);
        // each remaining enable alone must start the slow source
        @(posedge pclk);
        pwr_en <= 1'b1;
        @(posedge pclk);
        pwr_en <= 1'b0;
        two_en <= 1'b1;
        @(posedge pclk);
        two_en <= 1'b0;
        fs_en <= 1'b1;
        @(posedge pclk);
        fs_en <= 1'b0;
        mode <= omt_mode_e'(3'h3);
        meas(3, per);
        chk_rng(per, 160, 160);
        end_sim;
    end
endmodule
